// [include/tpt_defs.svh]
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port with byte offsets
// Notes:   definitions only
`ifndef TPT_DEFS_SVH
`define TPT_DEFS_SVH

// ************************
// register offsets
// ************************
`define TPT_OFS_SOURCE      8'h22
`define TPT_OFS_THS_X       8'h23
`define TPT_OFS_THS_Y       8'h24
`define TPT_OFS_THS_Z       8'h25
`define TPT_OFS_WIDTH       8'h26
`define TPT_OFS_LATENCY     8'h27
`define TPT_OFS_WINDOW      8'h28

// ************************
// reset values and field layout
// ************************
`define TPT_RST_THS         7'h00
`define TPT_RST_BYTE        8'h00
`define TPT_SRC_EA          7
`define TPT_SRC_AXIS_LSB    4
`define TPT_SRC_DPE         3
`define TPT_SRC_POL_LSB     0
`define TPT_THS_LOW_NOISE   7'h3F
`define TPT_MAG_FRAC        2

// ************************
// timing
// ************************
`define TPT_CLK_PERIOD_NS   5
`define TPT_BASE_STEP_NS    625000
`define TPT_PRESCALE_W      9
`define TPT_EXPO_W          4

`endif

// [include/tpt_pkg.sv]
// Purpose: shared types of the tap timing block
// Assumes: samples are signed 10-bit at the 8g scale
// Notes:   constants live in tpt_defs.svh
`default_nettype none
package tpt_pkg;

    typedef enum logic [1:0] {
        TAP_IDLE,
        TAP_LATENCY,
        TAP_WINDOW,
        TAP_SECOND
    } tpt_tap_e;

    typedef struct packed {
        logic              valid;
        logic signed [9:0] x;
        logic signed [9:0] y;
        logic signed [9:0] z;
    } tpt_sample_s;

    typedef struct packed {
        logic [2:0] sampleRate;
        logic [1:0] overMode;
        logic       tapFilterEnable;
        logic       lowNoise;
    } tpt_mode_s;

    typedef struct packed {
        logic       above;
        logic       started;
        logic       validPulse;
        logic       negative;
    } tpt_axis_s;

endpackage : tpt_pkg
`default_nettype wire

// [logic/tpt_step_timer.sv]
// Purpose: timing step pulse, base tick scaled by two to a power
// Assumes: base tick is 0.625 ms of the system clock
// Notes:   clear restarts the step so an interval starts whole
`timescale 1ns/10ps
`default_nettype none
`include "tpt_defs.svh"

module tpt_step_timer
    import tpt_pkg::*;
#(
    parameter int TICK_CYCLES = 125000
) (
    input  wire logic                    clock,
    input  wire logic                    rstn,
    input  wire logic                    clear,
    input  wire logic [`TPT_EXPO_W-1:0]  expo,
    output logic                         step
);

    localparam int DIV_W = $clog2(TICK_CYCLES);

    if (TICK_CYCLES < 2) begin : g_check
        $error("tpt_step_timer: TICK_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic [DIV_W-1:0]           div;
        logic [`TPT_PRESCALE_W-1:0] pre;
        logic                       step;
    } tpt_step_s;

    tpt_step_s st;
    tpt_step_s next_st;
    logic      tick;
    logic [`TPT_PRESCALE_W-1:0] preLast;

    always_comb begin
        next_st  = st;
        tick     = (st.div == DIV_W'(TICK_CYCLES - 1));
        preLast  = `TPT_PRESCALE_W'((1 << expo) - 1);
        next_st.step = 1'b0;
        if (clear) begin
            next_st.div = '0;
            next_st.pre = '0;
        end else if (tick) begin
            next_st.div = '0;
            if (st.pre >= preLast) begin
                next_st.pre  = '0;
                next_st.step = 1'b1;
            end else begin
                next_st.pre = st.pre + 1'b1;
            end
        end else begin
            next_st.div = st.div + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign step = st.step;

endmodule : tpt_step_timer
`default_nettype wire

// [logic/tpt_axis_detect.sv]
// Purpose: one axis of tap start and width checking
// Assumes: sample is signed at the 8g scale, 4 counts per threshold lsb
// Notes:   threshold of zero leaves the axis idle
`timescale 1ns/10ps
`default_nettype none
`include "tpt_defs.svh"

module tpt_axis_detect
    import tpt_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              sampleValid,
    input  wire logic signed [9:0] sample,
    input  wire logic [6:0]        threshold,
    input  wire logic              lowNoise,
    input  wire logic              widthStep,
    input  wire logic [7:0]        widthLimit,
    output tpt_axis_s              result
);

    typedef struct packed {
        tpt_axis_s  out;
        logic       tooLong;
        logic [7:0] count;
    } tpt_axst_s;

    tpt_axst_s  st;
    tpt_axst_s  next_st;
    logic [9:0] mag;
    logic [6:0] thrEff;
    logic       over;

    always_comb begin
        next_st = st;
        next_st.out.started    = 1'b0;
        next_st.out.validPulse = 1'b0;
        mag    = sample[9] ? 10'(-sample) : 10'(sample);         // [RQ20]
        thrEff = (lowNoise && threshold > `TPT_THS_LOW_NOISE)
               ? `TPT_THS_LOW_NOISE : threshold;                 // [RQ3]
        over   = (thrEff != 7'h00)
               && (mag > {1'b0, thrEff, 2'h0});                  // [RQ1] [RQ2]
        if (st.out.above && widthStep && !st.tooLong) begin
            if (st.count >= widthLimit) begin
                next_st.tooLong = 1'b1;                          // [RQ5]
            end else begin
                next_st.count = st.count + 1'b1;                 // [RQ19]
            end
        end
        if (sampleValid) begin
            if (over && !st.out.above) begin
                next_st.out.above    = 1'b1;
                next_st.out.started  = 1'b1;
                next_st.out.negative = sample[9];
                next_st.tooLong      = 1'b0;
                next_st.count        = 8'h00;
            end else if (!over && st.out.above) begin
                next_st.out.above      = 1'b0;
                next_st.out.validPulse = !next_st.tooLong;       // [RQ5]
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign result = st.out;

endmodule : tpt_axis_detect
`default_nettype wire

// [logic/tpt_tap_timing.sv]
// Purpose: tap thresholds, width limit, latency and second-tap window
// Assumes: host writes and reads registers through the byte port
// Notes:   rate, mode and filter bits arrive from registers elsewhere
`timescale 1ns/10ps
`default_nettype none
`include "tpt_defs.svh"

// What this block does
// [RQ1] separate threshold per axis starts detection
// [RQ2] unsigned 7-bit threshold, 0.063g per count
// [RQ3] low-noise mode caps threshold at 4g
// [RQ4] thresholds reset zero, bit 7 reads zero
// [RQ5] valid pulse ends within width limit
// [RQ6] width step follows rate, mode, filter
// [RQ7] filtered width steps per mode table
// [RQ8] unfiltered width steps per second table, half to a quarter of filtered
// [RQ9] latency after first tap ignores pulses
// [RQ10] host programs latency before relying on taps
// [RQ11] filtered latency steps per mode table
// [RQ12] unfiltered latency steps, max step times 255
// [RQ13] width limit register, read/write, reset zero
// [RQ14] latency register, read/write, reset zero
// [RQ15] filter enable selects step table
// [RQ16] window bounds second tap start
// [RQ17] second tap checks width, may end late
// [RQ18] source read clears flags and event
// [RQ19] timers count steps against programmed value
// [RQ20] threshold compares sample magnitude
module tpt_tap_timing
    import tpt_pkg::*;
#(
    parameter int BASE_TICK_CYCLES =
        `TPT_BASE_STEP_NS / `TPT_CLK_PERIOD_NS
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regWriteData,
    output logic      [7:0]  regReadData,
    input  wire tpt_sample_s sampleIn,
    input  wire tpt_mode_s   modeIn,
    output logic             tapEvent,
    output logic             singleTap,
    output logic             doubleTap
);

    // ************************
    // state
    // ************************
    typedef struct packed {
        tpt_tap_e   tap;
        logic [7:0] count;
        logic [6:0] x_threshold_field;
        logic [6:0] y_threshold_field;
        logic [6:0] z_threshold_field;
        logic [7:0] widthLimit;
        logic [7:0] latency;
        logic [7:0] window;
        logic [7:0] source;
        logic [7:0] readData;
        logic       singleTap;
        logic       doubleTap;
    } tpt_top_s;

    tpt_top_s  st;
    tpt_top_s  next_st;
    tpt_axis_s axX;
    tpt_axis_s axY;
    tpt_axis_s axZ;
    logic      widthStep;
    logic      latStep;
    logic      latClear;
    logic [`TPT_EXPO_W-1:0] widthExpo;
    logic [`TPT_EXPO_W-1:0] latExpo;
    logic [2:0] validAxes;
    logic [2:0] negAxes;
    logic       anyValid;
    logic       anyStart;
    logic       anyAbove;
    logic [7:0] newSource;
    logic       srcSet;

    // ************************
    // step size tables
    // ************************
    // returns the width step as a power of two of 0.625 ms
    function automatic logic [`TPT_EXPO_W-1:0] width_expo(
        input tpt_mode_s m
    );
        logic [3:0] r;
        logic [3:0] k;
        r = {1'b0, m.sampleRate};
        k = 4'h0;
        if (m.tapFilterEnable) begin                             // [RQ15]
            case (m.overMode)                                    // [RQ7]
                2'h0:    k = (r < 4'h4) ? r + 4'h1 : 4'h5;
                2'h1:    k = (r < 4'h5) ? r + 4'h1 : 4'h7;
                2'h2:    k = (r < 4'h1) ? 4'h1 : 4'h2;
                2'h3:    k = (r < 4'h5) ? r + 4'h1
                           : ((r == 4'h5) ? 4'h7 : 4'h8);
                default: k = 4'h1;
            endcase
        end else begin
            case (m.overMode)                                    // [RQ8]
                2'h0:    k = (r < 4'h2) ? 4'h0
                           : ((r < 4'h5) ? r - 4'h1 : 4'h3);
                2'h1:    k = (r < 4'h2) ? 4'h0
                           : ((r < 4'h5) ? r - 4'h1 : 4'h5);
                2'h2:    k = 4'h0;
                2'h3:    k = (r < 4'h5) ? r : 4'h6;
                default: k = 4'h0;
            endcase
        end
        return k;
    endfunction : width_expo

    assign widthExpo = width_expo(modeIn);                       // [RQ6]
    assign latExpo   = widthExpo + 4'h1;                         // [RQ11] [RQ12]

    // ************************
    // timers and axes
    // ************************
    tpt_step_timer #(
        .TICK_CYCLES (BASE_TICK_CYCLES)
    ) u_width_step (
        .clock (clock),
        .rstn  (rstn),
        .clear (1'b0),
        .expo  (widthExpo),
        .step  (widthStep)
    );

    tpt_step_timer #(
        .TICK_CYCLES (BASE_TICK_CYCLES)
    ) u_lat_step (
        .clock (clock),
        .rstn  (rstn),
        .clear (latClear),
        .expo  (latExpo),
        .step  (latStep)
    );

    tpt_axis_detect u_axis_x (
        .clock       (clock),
        .rstn        (rstn),
        .sampleValid (sampleIn.valid),
        .sample      (sampleIn.x),
        .threshold   (st.x_threshold_field),
        .lowNoise    (modeIn.lowNoise),
        .widthStep   (widthStep),
        .widthLimit  (st.widthLimit),
        .result      (axX)
    );

    tpt_axis_detect u_axis_y (
        .clock       (clock),
        .rstn        (rstn),
        .sampleValid (sampleIn.valid),
        .sample      (sampleIn.y),
        .threshold   (st.y_threshold_field),
        .lowNoise    (modeIn.lowNoise),
        .widthStep   (widthStep),
        .widthLimit  (st.widthLimit),
        .result      (axY)
    );

    tpt_axis_detect u_axis_z (
        .clock       (clock),
        .rstn        (rstn),
        .sampleValid (sampleIn.valid),
        .sample      (sampleIn.z),
        .threshold   (st.z_threshold_field),
        .lowNoise    (modeIn.lowNoise),
        .widthStep   (widthStep),
        .widthLimit  (st.widthLimit),
        .result      (axZ)
    );

    assign validAxes = {axZ.validPulse, axY.validPulse, axX.validPulse};
    assign negAxes   = {axZ.negative, axY.negative, axX.negative};
    assign anyValid  = |validAxes;
    assign anyStart  = axX.started | axY.started | axZ.started;
    assign anyAbove  = axX.above | axY.above | axZ.above;
    assign latClear  = (st.tap == TAP_IDLE) || (st.tap == TAP_SECOND);

    // ************************
    // next state
    // ************************
    always_comb begin
        next_st = st;
        next_st.singleTap = 1'b0;
        next_st.doubleTap = 1'b0;
        srcSet    = 1'b0;
        newSource = 8'h00;
        newSource[`TPT_SRC_EA] = 1'b1;
        newSource[`TPT_SRC_AXIS_LSB +: 3] = validAxes;
        newSource[`TPT_SRC_POL_LSB +: 3]  = negAxes & validAxes;

        case (st.tap)
            TAP_IDLE: begin
                if (anyValid) begin
                    srcSet            = 1'b1;
                    next_st.singleTap = 1'b1;
                    next_st.count     = 8'h00;
                    next_st.tap       = TAP_LATENCY;             // [RQ9]
                end
            end
            TAP_LATENCY: begin
                // pulses in this interval are not looked at
                if (st.count >= st.latency) begin                // [RQ9] [RQ19]
                    next_st.count = 8'h00;
                    next_st.tap   = TAP_WINDOW;
                end else if (latStep) begin
                    next_st.count = st.count + 1'b1;             // [RQ19]
                end
            end
            TAP_WINDOW: begin
                if (anyStart) begin
                    next_st.tap = TAP_SECOND;                    // [RQ16]
                end else if (st.count >= st.window) begin
                    next_st.tap = TAP_IDLE;                      // [RQ16]
                end else if (latStep) begin
                    next_st.count = st.count + 1'b1;             // [RQ19]
                end
            end
            TAP_SECOND: begin
                // window no longer bounds the end of this pulse
                if (anyValid) begin                              // [RQ17]
                    srcSet                 = 1'b1;
                    newSource[`TPT_SRC_DPE] = 1'b1;
                    next_st.doubleTap      = 1'b1;
                    next_st.tap            = TAP_IDLE;
                end else if (!anyAbove) begin
                    next_st.tap = TAP_IDLE;                      // [RQ17]
                end
            end
            default: begin
                next_st.tap = TAP_IDLE;
            end
        endcase

        // ************************
        // register port
        // ************************
        if (regWrite) begin
            case (regAddr)
                `TPT_OFS_THS_X:   next_st.x_threshold_field = regWriteData[6:0]; // [RQ4]
                `TPT_OFS_THS_Y:   next_st.y_threshold_field = regWriteData[6:0]; // [RQ4]
                `TPT_OFS_THS_Z:   next_st.z_threshold_field = regWriteData[6:0]; // [RQ4]
                `TPT_OFS_WIDTH:   next_st.widthLimit = regWriteData; // [RQ13]
                `TPT_OFS_LATENCY: next_st.latency = regWriteData;   // [RQ14]
                `TPT_OFS_WINDOW:  next_st.window = regWriteData;
                default:          ;
            endcase
        end

        if (regRead) begin
            case (regAddr)
                `TPT_OFS_SOURCE:  next_st.readData = st.source;
                `TPT_OFS_THS_X:   next_st.readData = {1'b0, st.x_threshold_field}; // [RQ4]
                `TPT_OFS_THS_Y:   next_st.readData = {1'b0, st.y_threshold_field};
                `TPT_OFS_THS_Z:   next_st.readData = {1'b0, st.z_threshold_field};
                `TPT_OFS_WIDTH:   next_st.readData = st.widthLimit;
                `TPT_OFS_LATENCY: next_st.readData = st.latency;
                `TPT_OFS_WINDOW:  next_st.readData = st.window;
                default:          next_st.readData = 8'h00;
            endcase
            if (regAddr == `TPT_OFS_SOURCE) begin
                next_st.source = 8'h00;                          // [RQ18]
            end
        end

        // a new event in the reading cycle survives the clear
        if (srcSet) begin
            next_st.source = newSource;
        end
    end

    // ************************
    // registers
    // ************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st            <= '0;
            st.tap        <= TAP_IDLE;
            st.x_threshold_field       <= `TPT_RST_THS;                       // [RQ4]
            st.y_threshold_field       <= `TPT_RST_THS;
            st.z_threshold_field       <= `TPT_RST_THS;
            st.widthLimit <= `TPT_RST_BYTE;                      // [RQ13]
            st.latency    <= `TPT_RST_BYTE;                      // [RQ14]
            st.window     <= `TPT_RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    assign regReadData = st.readData;
    assign tapEvent    = st.source[`TPT_SRC_EA];                 // [RQ18]
    assign singleTap   = st.singleTap;
    assign doubleTap   = st.doubleTap;

endmodule : tpt_tap_timing
`default_nettype wire

// [verif/tpt_host_model.sv]
// Purpose: host side of the byte register port
// Assumes: strobes change at the falling clock edge
// Notes:   data is taken the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module tpt_host_model (
    input  wire logic       clock,
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regWriteData,
    input  wire logic [7:0] regReadData
);
    initial begin
        {regAddr, regWrite, regRead, regWriteData} = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr      = a;
        regWriteData = d;
        regWrite     = 1'h1;
        @(negedge clock);
        regWrite     = 1'h0;
        regAddr      = ~a;
        regWriteData = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regRead = 1'h1;
        @(negedge clock);
        regRead = 1'h0;
        regAddr = ~a;
        d       = regReadData;
    endtask : rd
endmodule : tpt_host_model
`default_nettype wire

// [verif/tpt_tap_timing_chk.sv]
// Purpose: port checks of the tap timing block
// Assumes: one clock domain, reset active low
// Notes:   bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none
module tpt_tap_timing_chk
    import tpt_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regWriteData,
    input  wire logic [7:0]  regReadData,
    input  wire tpt_sample_s sampleIn,
    input  wire tpt_mode_s   modeIn,
    input  wire logic        tapEvent,
    input  wire logic        singleTap,
    input  wire logic        doubleTap
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic srcRead;
    assign srcRead = regRead && regAddr == 8'h22;

    property p_tap_after_end;
        (singleTap || doubleTap) |-> $past(sampleIn.valid, 2);
    endproperty
    a_tap_after_end: assert property (p_tap_after_end)
        else $error("late tap");
    property p_single_short;
        singleTap |=> !singleTap && !doubleTap;
    endproperty
    a_single_short: assert property (p_single_short)
        else $error("tap after tap");
    property p_no_both;
        !(singleTap && doubleTap);
    endproperty
    a_no_both: assert property (p_no_both)
        else $error("both taps");
    property p_event_set;
        (singleTap || doubleTap) |-> tapEvent;
    endproperty
    a_event_set: assert property (p_event_set)
        else $error("no event");
    property p_event_rise;
        $rose(tapEvent) |-> singleTap || doubleTap;
    endproperty
    a_event_rise: assert property (p_event_rise)
        else $error("stray event");
    property p_read_clear;
        srcRead |=> !tapEvent || singleTap || doubleTap;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("event kept");
    property p_event_hold;
        tapEvent && !srcRead |=> tapEvent;
    endproperty
    a_event_hold: assert property (p_event_hold)
        else $error("event lost");
    property p_thr_msb;
        regRead && regAddr inside {8'h23, 8'h24, 8'h25}
            |=> !regReadData[7];
    endproperty
    a_thr_msb: assert property (p_thr_msb)
        else $error("msb set");
    property p_latency_back;
        regWrite && regAddr == 8'h27 ##2 regRead && regAddr == 8'h27
            |=> regReadData == $past(regWriteData, 3);
    endproperty
    a_latency_back: assert property (p_latency_back)
        else $error("bad latency");
    property p_read_hold;
        !regRead |=> $stable(regReadData);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("data moved");
endmodule : tpt_tap_timing_chk

bind tpt_tap_timing tpt_tap_timing_chk chk (
    .clock(clock), .rstn(rstn), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead),
    .regWriteData(regWriteData), .regReadData(regReadData),
    .sampleIn(sampleIn), .modeIn(modeIn), .tapEvent(tapEvent),
    .singleTap(singleTap), .doubleTap(doubleTap)
);
`default_nettype wire

// [verif/tpt_tap_timing_tb.sv]
// Purpose: self-checking bench of the tap timing block
// Assumes: base tick of 4 cycles, width step 4, latency step 8
// Notes:   inputs change at the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module tpt_tap_timing_tb
    import tpt_pkg::*;
;
    logic        clock;
    logic        rstn;
    logic [7:0]  regAddr;
    logic        regWrite;
    logic        regRead;
    logic [7:0]  regWriteData;
    logic [7:0]  regReadData;
    tpt_sample_s sampleIn;
    tpt_mode_s   modeIn;
    logic        tapEvent;
    logic        singleTap;
    logic        doubleTap;
    logic [7:0]  rdv;
    logic        gotS;
    logic        gotD;
    int          n_fail;
    int          cmp_count;

    tpt_tap_timing #(.BASE_TICK_CYCLES(4)) dut (
        .clock(clock), .rstn(rstn), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead),
        .regWriteData(regWriteData), .regReadData(regReadData),
        .sampleIn(sampleIn), .modeIn(modeIn), .tapEvent(tapEvent),
        .singleTap(singleTap), .doubleTap(doubleTap)
    );
    tpt_host_model host (
        .clock(clock), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWriteData(regWriteData),
        .regReadData(regReadData)
    );
    always #2.5 clock = ~clock;

    task automatic check(input string w, input logic [7:0] s,
                         input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", w, e, s);
        end
    endtask : check

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // ********************
    // sample driving
    // ********************
    task automatic put(input int ax, input logic signed [9:0] v);
        @(negedge clock);
        sampleIn.valid = 1'h1;
        sampleIn.x     = (ax == 0) ? v : 10'sh000;
        sampleIn.y     = (ax == 1) ? v : 10'sh000;
        sampleIn.z     = (ax == 2) ? v : 10'sh000;
        @(negedge clock);
        sampleIn.valid = 1'h0;
        sampleIn.x     = ~sampleIn.x;
        sampleIn.y     = ~sampleIn.y;
        sampleIn.z     = ~sampleIn.z;
    endtask : put

    task automatic tap(input int ax, input logic signed [9:0] v,
                       input int wide);
        put(ax, v);
        repeat (wide) @(negedge clock);
        put(ax, 10'sh000);
        gotS = 1'h0;
        gotD = 1'h0;
        repeat (4) begin
            @(negedge clock);
            gotS |= singleTap;
            gotD |= doubleTap;
        end
    endtask : tap

    // ********************
    // scenarios
    // ********************
    task automatic t_regs;
        logic [7:0] d;
        for (int i = 0; i < 7; i++) begin
            host.rd(8'h22 + 8'(i), rdv);
            check("reset", rdv, 8'h00);
            d = 8'hA5 + 8'(i);
            host.wr(8'h22 + 8'(i), d);
            host.rd(8'h22 + 8'(i), rdv);
            d = (i == 0) ? 8'h00 : (i < 4) ? (d & 8'h7F) : d;
            check("readback", rdv, d);
        end
        host.wr(8'h30, 8'hFF);
        host.rd(8'h30, rdv);
        check("unmapped", rdv, 8'h00);
    endtask : t_regs

    task automatic t_axes;
        logic [7:0] e;
        for (int ax = 0; ax < 3; ax++) begin
            tap(ax, (ax == 1) ? -10'sh064 : 10'sh064, 2);
            check("single", 8'(gotS), 8'h01);
            check("event", 8'(tapEvent), 8'h01);
            e = 8'h80 | (8'h10 << ax) | ((ax == 1) ? 8'h02 : 8'h00);
            host.rd(8'h22, rdv);
            check("source", rdv, e);
            check("cleared", 8'(tapEvent), 8'h00);
            repeat (20) @(negedge clock);
        end
    endtask : t_axes

    task automatic t_thr;
        host.wr(8'h25, 8'h00);
        tap(2, 10'sh12C, 2);
        check("axis off", 8'(gotS), 8'h00);
        tap(0, 10'sh028, 2);
        check("at thr", 8'(gotS), 8'h00);
        tap(0, -10'sh029, 2);
        check("over thr", 8'(gotS), 8'h01);
        repeat (20) @(negedge clock);
        host.wr(8'h23, 8'h64);
        tap(0, 10'sh12C, 2);
        check("full range", 8'(gotS), 8'h00);
        modeIn.lowNoise = 1'h1;
        tap(0, 10'sh12C, 2);
        check("low noise", 8'(gotS), 8'h01);
        modeIn.lowNoise = 1'h0;
        host.wr(8'h23, 8'h0A);
        repeat (20) @(negedge clock);
    endtask : t_thr

    task automatic t_steps;
        int t[6][4] = '{'{0, 0, 1, 1}, '{0, 0, 0, 0}, '{1, 3, 0, 1},
                        '{1, 0, 0, 0}, '{2, 0, 0, 1}, '{2, 2, 0, 0}};
        for (int i = 0; i < 6; i++) begin
            modeIn.sampleRate      = 3'(t[i][0]);
            modeIn.overMode        = 2'(t[i][1]);
            modeIn.tapFilterEnable = 1'(t[i][2]);
            tap(0, 10'sh064, 34);
            check("step", 8'(gotS), 8'(t[i][3]));
            repeat (60) @(negedge clock);
        end
        modeIn = '0;
    endtask : t_steps

    task automatic t_latency;
        host.wr(8'h27, 8'h14);
        tap(0, 10'sh064, 2);
        check("first", 8'(gotS), 8'h01);
        repeat (120) @(negedge clock);
        tap(1, 10'sh064, 2);
        check("ignored", 8'({gotS, gotD}), 8'h00);
        repeat (60) @(negedge clock);
        tap(1, 10'sh064, 2);
        check("after", 8'(gotS), 8'h01);
        repeat (200) @(negedge clock);
    endtask : t_latency

    task automatic t_double;
        host.wr(8'h26, 8'h0A);
        host.wr(8'h27, 8'h04);
        host.wr(8'h28, 8'h04);
        tap(0, 10'sh064, 2);
        repeat (40) @(negedge clock);
        tap(0, 10'sh064, 30);
        check("double", 8'({gotS, gotD}), 8'h01);
        host.rd(8'h22, rdv);
        check("dbl source", rdv, 8'h98);
        repeat (100) @(negedge clock);
        tap(0, 10'sh064, 2);
        repeat (90) @(negedge clock);
        tap(0, 10'sh064, 2);
        check("late", 8'({gotS, gotD}), 8'h02);
    endtask : t_double

    initial begin
        clock     = 1'h0;
        rstn      = 1'h0;
        sampleIn  = '0;
        modeIn    = '0;
        n_fail    = 0;
        cmp_count = 0;
        repeat (2) @(negedge clock);
        rstn = 1'h1;
        t_regs();
        host.wr(8'h27, 8'h01);
        host.wr(8'h23, 8'h0A);
        host.wr(8'h24, 8'h0A);
        host.wr(8'h25, 8'h0A);
        host.wr(8'h26, 8'h06);
        host.wr(8'h28, 8'h00);
        t_axes();
        t_thr();
        t_steps();
        t_latency();
        t_double();
        report_and_stop();
    end

    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end
endmodule : tpt_tap_timing_tb
`default_nettype wire
